// ---- rtl/wdr_pkg.sv ----
// watchdog register block: shared offsets, field positions, reset values
// assumes APB with 12-bit word-aligned byte offsets inside the block
package wdr_pkg;
  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [11:0] OFF_START = 12'h000;
  localparam logic [11:0] OFF_EVENT = 12'h100;
  localparam logic [11:0] OFF_PUBLISH = 12'h180;
  localparam logic [11:0] OFF_IRQ_SET = 12'h304;
  localparam logic [11:0] OFF_IRQ_CLR = 12'h308;
  localparam logic [11:0] OFF_RUN = 12'h400;
  localparam logic [11:0] OFF_REQ = 12'h404;
  localparam logic [11:0] OFF_CRV = 12'h504;
  localparam logic [11:0] OFF_SLOT_EN = 12'h508;
  localparam logic [11:0] OFF_CONFIG = 12'h50C;
  localparam logic [11:0] OFF_SLOT_BASE = 12'h600;
  localparam logic [11:0] OFF_SLOT_LAST = 12'h61C;
  // ----------------------------------------
  // fields and reset values
  // ----------------------------------------
  localparam int NUM_SLOTS = 8;
  localparam int CHAN_W = 16;
  localparam int PUB_EN_BIT = 31;
  localparam int CFG_SLEEP_BIT = 0;
  localparam int CFG_HALT_BIT = 3;
  localparam logic [31:0] RELOAD_MAGIC = 32'h6E524635;
  localparam logic [31:0] PUBLISH_RST = 32'h00000000;
  localparam logic [7:0] SLOT_EN_RST = 8'h01;
  localparam logic CFG_SLEEP_RST = 1'h1;
  localparam logic CFG_HALT_RST = 1'h0;
  localparam logic [31:0] CRV_RST = 32'hFFFFFFFF;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int MCLK_HZ = 200000000;
  localparam int LF_HZ = 32768;
  localparam int LF_DIV_DEF = MCLK_HZ / LF_HZ;
  localparam logic [1:0] IRQ_RESET_DELAY = 2'h2;
endpackage

// ---- rtl/wdr_counter.sv ----
// watchdog down-counter on the low-frequency tick
// assumes tick is a one-cycle strobe on mclk
`timescale 1ns/10ps
module wdr_counter import wdr_pkg::*; (
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // control
  input wire logic tick,
  input wire logic load,
  input wire logic run,
  input wire logic hold,
  input wire logic [31:0] reload_value,
  // result
  output logic [31:0] count,
  output logic timeout
);
  // period is reload_value + 1 ticks: zero is counted as a tick of its own
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      count <= CRV_RST;
    end else if (load) begin
      count <= reload_value;
    end else if (run && tick && !hold) begin
      if (count == 32'h00000000) begin
        count <= reload_value;
      end else begin
        count <= count - 32'h00000001;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      timeout <= 1'b0;
    end else begin
      timeout <= run && tick && !hold && !load && (count == 32'h00000000);
    end
  end
endmodule

// ---- rtl/wdr_regs.sv ----
// watchdog register block with APB slave, reload slots and reset request
// assumes nrst clears the block after a watchdog reset or wake from off
//
// How it works
// - publish register holds a read-write channel index in bits 15..0.
// - publish bit 31 enables timeout publishing; register resets to zero.
// - write 1 to irq set bit enables interrupt; read shows enable.
// - eight slot enable bits, only slot 0 enabled after reset.
// - config bit 0 low pauses countdown while cpu sleeps; resets high.
// - config bit 3 low pauses countdown while cpu halted; resets low.
// - only the exact magic value written to a slot counts as request.
// - 32-bit counter gives intervals from one tick up to 36 hours.
// - timeout period is reload value plus one low-frequency ticks.
// - reload only when every enabled slot has received the magic value.
// - once running, reload value, slot enable and config writes ignored.
// - timeout always resets; delayed two ticks when interrupt enabled.
`timescale 1ns/10ps
module wdr_regs import wdr_pkg::*; #(
  parameter int LF_DIV = LF_DIV_DEF
) (
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // processor state pins
  input wire logic cpu_sleeping,
  input wire logic cpu_halted,
  // results
  output logic irq,
  output logic wdt_reset,
  output logic publish_pulse,
  output logic [CHAN_W-1:0] publish_channel
);
  // ----------------------------------------
  // declarations
  // ----------------------------------------
  logic [1:0] sleep_sync;
  logic [1:0] halt_sync;
  logic [12:0] div_cnt;
  logic tick;
  logic running;
  logic [31:0] publish_cfg;
  logic inten;
  logic event_flag;
  logic [31:0] counter_reload_value;
  logic [NUM_SLOTS-1:0] slot_en;
  logic cfg_sleep;
  logic cfg_halt;
  logic [NUM_SLOTS-1:0] slot_done;
  logic [NUM_SLOTS-1:0] magic_now;
  logic reload;
  logic hold;
  logic timeout;
  logic [31:0] count;
  logic reset_pending;
  logic [1:0] delay_cnt;
  logic wr;
  logic access;
  logic [31:0] next_rdata;
  logic next_err;

  function automatic logic is_slot(input logic [11:0] addr);
    is_slot = (addr >= OFF_SLOT_BASE) && (addr <= OFF_SLOT_LAST) && (addr[1:0] == 2'h0);
  endfunction

  function automatic logic hit(input logic [11:0] addr, input logic [11:0] off);
    hit = (addr == off);
  endfunction

  // ----------------------------------------
  // apb handshake
  // ----------------------------------------
  // one wait state so read data comes from a flop
  assign access = psel && penable;
  assign wr = access && pready && pwrite;

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      pready <= 1'b0;
    end else begin
      pready <= access && !pready;
    end
  end

  always_comb begin
    next_rdata = 32'h00000000;
    next_err = 1'b0;
    if (is_slot(paddr)) begin
      next_rdata = 32'h00000000;
    end else begin
      case (paddr)
        OFF_START: next_rdata = 32'h00000000;
        OFF_EVENT: next_rdata = {31'h00000000, event_flag};
        OFF_PUBLISH: next_rdata = publish_cfg;
        OFF_IRQ_SET: next_rdata = {31'h00000000, inten};
        OFF_IRQ_CLR: next_rdata = {31'h00000000, inten};
        OFF_RUN: next_rdata = {31'h00000000, running};
        OFF_REQ: next_rdata = {24'h000000, slot_en & ~slot_done};
        OFF_CRV: next_rdata = counter_reload_value;
        OFF_SLOT_EN: next_rdata = {24'h000000, slot_en};
        OFF_CONFIG: next_rdata = {28'h0000000, cfg_halt, 2'h0, cfg_sleep};
        default: next_err = 1'b1;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (access && !pready) begin
      prdata <= pwrite ? 32'h00000000 : next_rdata;
      pslverr <= next_err;
    end else begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end
  end

  // ----------------------------------------
  // pin synchronisers and low-frequency tick
  // ----------------------------------------
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      sleep_sync <= 2'h0;
      halt_sync <= 2'h0;
    end else begin
      sleep_sync <= {sleep_sync[0], cpu_sleeping};
      halt_sync <= {halt_sync[0], cpu_halted};
    end
  end

  // integer divide: tick rate is slightly above the nominal 32768 Hz
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      div_cnt <= 13'h0000;
      tick <= 1'b0;
    end else if (div_cnt == 13'(LF_DIV - 1)) begin
      div_cnt <= 13'h0000;
      tick <= 1'b1;
    end else begin
      div_cnt <= div_cnt + 13'h0001;
      tick <= 1'b0;
    end
  end

  // ----------------------------------------
  // configuration registers
  // ----------------------------------------
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      publish_cfg <= PUBLISH_RST;
    end else if (wr && hit(paddr, OFF_PUBLISH)) begin
      publish_cfg <= {pwdata[PUB_EN_BIT], 15'h0000, pwdata[CHAN_W-1:0]};
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      inten <= 1'b0;
    end else if (wr && hit(paddr, OFF_IRQ_SET) && pwdata[0]) begin
      inten <= 1'b1;
    end else if (wr && hit(paddr, OFF_IRQ_CLR) && pwdata[0]) begin
      inten <= 1'b0;
    end
  end

  // locked while running; only nrst frees them again
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      counter_reload_value <= CRV_RST;
      slot_en <= SLOT_EN_RST;
      cfg_sleep <= CFG_SLEEP_RST;
      cfg_halt <= CFG_HALT_RST;
    end else if (wr && !running) begin
      if (hit(paddr, OFF_CRV)) begin
        counter_reload_value <= pwdata;
      end
      if (hit(paddr, OFF_SLOT_EN)) begin
        slot_en <= pwdata[NUM_SLOTS-1:0];
      end
      if (hit(paddr, OFF_CONFIG)) begin
        cfg_sleep <= pwdata[CFG_SLEEP_BIT];
        cfg_halt <= pwdata[CFG_HALT_BIT];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      running <= 1'b0;
    end else if (wr && hit(paddr, OFF_START) && pwdata[0]) begin
      running <= 1'b1;
    end
  end

  // ----------------------------------------
  // reload slots
  // ----------------------------------------
  // slot contents are not readable, so only a done flag per slot is kept
  always_comb begin
    magic_now = '0;
    for (int i = 0; i < NUM_SLOTS; i++) begin
      if (wr && is_slot(paddr) && paddr[4:2] == 3'(i) && pwdata == RELOAD_MAGIC) begin
        magic_now[i] = 1'b1;
      end
    end
  end

  assign reload = running && (((slot_done | magic_now) & slot_en) == slot_en);

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      slot_done <= '0;
    end else if (reload) begin
      slot_done <= '0;
    end else begin
      slot_done <= slot_done | (magic_now & slot_en);
    end
  end

  // ----------------------------------------
  // countdown
  // ----------------------------------------
  assign hold = (sleep_sync[1] && !cfg_sleep) || (halt_sync[1] && !cfg_halt);

  wdr_counter u_counter (
    .mclk(mclk),
    .nrst(nrst),
    .tick(tick),
    .load(reload || (wr && hit(paddr, OFF_START) && !running)),
    .run(running),
    .hold(hold),
    .reload_value(counter_reload_value),
    .count(count),
    .timeout(timeout)
  );

  // ----------------------------------------
  // event, interrupt, publish and reset
  // ----------------------------------------
  // a timeout in the clearing cycle keeps the flag set
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      event_flag <= 1'b0;
    end else if (timeout) begin
      event_flag <= 1'b1;
    end else if (wr && hit(paddr, OFF_EVENT) && !pwdata[0]) begin
      event_flag <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      irq <= 1'b0;
    end else begin
      irq <= event_flag && inten;
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      publish_pulse <= 1'b0;
      publish_channel <= '0;
    end else begin
      publish_pulse <= timeout && publish_cfg[PUB_EN_BIT];
      if (timeout) begin
        publish_channel <= publish_cfg[CHAN_W-1:0];
      end
    end
  end

  // the pending reset cannot be cancelled by software
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      reset_pending <= 1'b0;
      delay_cnt <= 2'h0;
      wdt_reset <= 1'b0;
    end else if (timeout && !reset_pending && !wdt_reset) begin
      if (inten) begin
        reset_pending <= 1'b1;
        delay_cnt <= 2'h0;
      end else begin
        wdt_reset <= 1'b1;
      end
    end else if (reset_pending && tick) begin
      if (delay_cnt == IRQ_RESET_DELAY - 2'h1) begin
        reset_pending <= 1'b0;
        wdt_reset <= 1'b1;
      end else begin
        delay_cnt <= delay_cnt + 2'h1;
      end
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  // cycles spent waiting for the delayed reset; too long for a delay range
  logic [15:0] pend_cycles;

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      pend_cycles <= 16'h0000;
    end else if (reset_pending) begin
      pend_cycles <= pend_cycles + 16'h0001;
    end else begin
      pend_cycles <= 16'h0000;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  chk_publish_pulse: assert property (
    timeout && publish_cfg[PUB_EN_BIT] |=> publish_pulse && publish_channel == $past(publish_cfg[15:0]))
    else $error("publish pulse missing or wrong channel");
  chk_publish_quiet: assert property (
    !publish_cfg[PUB_EN_BIT] |=> !publish_pulse)
    else $error("publish pulse while disabled");
  chk_irq_follow: assert property (
    event_flag && inten |=> irq)
    else $error("irq not raised");
  chk_inten_set: assert property (
    wr && paddr == OFF_IRQ_SET && pwdata[0] |=> inten ##1 irq == $past(event_flag))
    else $error("irq enable set failed");
  chk_cfg_locked: assert property (
    running |=> $stable(counter_reload_value) && $stable(slot_en) && $stable(cfg_sleep) && $stable(cfg_halt))
    else $error("config changed while running");
  chk_slot_write: assert property (
    wr && !running && paddr == OFF_SLOT_EN |=> slot_en == $past(pwdata[7:0]))
    else $error("slot enable write lost");
  chk_magic_only: assert property (
    wr && is_slot(paddr) && pwdata != RELOAD_MAGIC && !reload |=> slot_done == $past(slot_done))
    else $error("non-magic write counted");
  chk_reload_all: assert property (
    reload |-> running ##1 slot_done == '0 && count == $past(counter_reload_value))
    else $error("reload did not restart count");
  chk_sleep_pause: assert property (
    sleep_sync[1] && !cfg_sleep && running && !reload |=> count == $past(count))
    else $error("counted while sleeping paused");
  chk_reset_now: assert property (
    timeout && !inten && !reset_pending |=> wdt_reset)
    else $error("reset not immediate");
  chk_reset_delay: assert property (
    timeout && inten && !reset_pending && !wdt_reset |=> reset_pending && !wdt_reset)
    else $error("delayed reset wrong");
  chk_delay_bound: assert property (
    reset_pending |-> !wdt_reset && pend_cycles < 16'(2 * LF_DIV))
    else $error("delayed reset overdue");
  chk_delay_end: assert property (
    $fell(reset_pending) |-> wdt_reset && $past(pend_cycles) >= 16'(LF_DIV))
    else $error("delayed reset too early");

  cov_reload: cover property (reload);
  cov_timeout_irq: cover property (timeout && inten);
  cov_publish: cover property (publish_pulse);
  cov_locked_write: cover property (wr && running && paddr == OFF_CRV);
endmodule

// ---- dv/wdr_regs_bench.sv ----
// self-checking bench for the watchdog register block
// assumes wdr_pkg is compiled first and LF_DIV is shortened to 4 mclk cycles per tick
`timescale 1ns/10ps
module wdr_regs_bench import wdr_pkg::*;;
  localparam int DIV = 4;
  typedef struct {logic w; logic [11:0] a; logic [31:0] d; logic [31:0] e; logic err;} wdr_row_t;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic cpu_sleeping = 1'b0;
  logic cpu_halted = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, irq, wdt_reset, publish_pulse;
  logic [CHAN_W-1:0] publish_channel;
  int num_errors = 0;
  int n_compared = 0;
  int n_pulse = 0;
  int n;
  logic [31:0] rd;
  logic err;
  wdr_row_t rows [0:18] = '{
    '{1'b0, OFF_PUBLISH, 32'h0, PUBLISH_RST, 1'b0}, '{1'b0, OFF_IRQ_SET, 32'h0, 32'h0, 1'b0},
    '{1'b0, OFF_SLOT_EN, 32'h0, 32'h1, 1'b0}, '{1'b0, OFF_CONFIG, 32'h0, 32'h1, 1'b0},
    '{1'b0, OFF_CRV, 32'h0, CRV_RST, 1'b0}, '{1'b0, OFF_SLOT_LAST, 32'h0, 32'h0, 1'b0},
    '{1'b0, 12'h7F0, 32'h0, 32'h0, 1'b1}, '{1'b1, 12'h7F0, 32'h1, 32'h0, 1'b1},
    '{1'b1, OFF_PUBLISH, 32'h800000AB, 32'h0, 1'b0},
    '{1'b0, OFF_PUBLISH, 32'h0, 32'h800000AB, 1'b0},
    '{1'b1, OFF_IRQ_SET, 32'h0, 32'h0, 1'b0}, '{1'b0, OFF_IRQ_SET, 32'h0, 32'h0, 1'b0},
    '{1'b1, OFF_IRQ_SET, 32'h1, 32'h0, 1'b0}, '{1'b0, OFF_IRQ_SET, 32'h0, 32'h1, 1'b0},
    '{1'b1, OFF_SLOT_EN, 32'h3, 32'h0, 1'b0}, '{1'b0, OFF_SLOT_EN, 32'h0, 32'h3, 1'b0},
    '{1'b1, OFF_CONFIG, 32'h0, 32'h0, 1'b0}, '{1'b1, OFF_CRV, 32'h14, 32'h0, 1'b0},
    '{1'b0, OFF_CRV, 32'h0, 32'h14, 1'b0}};

  wdr_regs #(.LF_DIV(DIV)) wdr_regs_i (
    .mclk(mclk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cpu_sleeping(cpu_sleeping), .cpu_halted(cpu_halted), .irq(irq), .wdt_reset(wdt_reset),
    .publish_pulse(publish_pulse), .publish_channel(publish_channel));

  always #2.5 mclk = ~mclk;
  always @(posedge mclk) if (publish_pulse === 1'b1) n_pulse++;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // an extra edge before setup keeps psel from being driven twice in one step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1 && k < 20) begin
      @(posedge mclk);
      k++;
    end
    if (k == 20) num_errors++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask

  task automatic do_reset();
    nrst <= 1'b0;
    repeat (5) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
  endtask

  task automatic wait_reset_out(input int lim);
    n = 0;
    while (wdt_reset !== 1'b1 && n < lim) begin
      @(posedge mclk);
      n++;
    end
  endtask

  task automatic final_report();
    $display("compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    #(5 * 6000);
    num_errors++;
    final_report();
  end

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    do_reset();
    chk({31'h0, wdt_reset}, 32'h0);
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w) chk(rd, rows[i].e);
      chk({31'h0, err}, {31'h0, rows[i].err});
    end
    $display("test register table done");
    apb(1'b1, OFF_START, 32'h1);
    rdchk(OFF_RUN, 32'h1);
    rdchk(OFF_REQ, 32'h3);
    apb(1'b1, OFF_CRV, 32'h5);
    rdchk(OFF_CRV, 32'h14);
    apb(1'b1, OFF_SLOT_EN, 32'hFF);
    rdchk(OFF_SLOT_EN, 32'h3);
    apb(1'b1, OFF_CONFIG, 32'h9);
    rdchk(OFF_CONFIG, 32'h0);
    apb(1'b1, OFF_SLOT_BASE, RELOAD_MAGIC);
    rdchk(OFF_REQ, 32'h2);
    apb(1'b1, OFF_SLOT_LAST, RELOAD_MAGIC);
    apb(1'b1, OFF_SLOT_BASE + 12'h004, 32'h6E524634);
    rdchk(OFF_REQ, 32'h2);
    apb(1'b1, OFF_SLOT_BASE + 12'h004, RELOAD_MAGIC);
    rdchk(OFF_REQ, 32'h3);
    $display("test locking and reload done");
    // both pauses outlast a full period of 21 ticks
    cpu_halted <= 1'b1;
    repeat (150) @(posedge mclk);
    cpu_halted <= 1'b0;
    cpu_sleeping <= 1'b1;
    repeat (150) @(posedge mclk);
    chk(n_pulse, 0);
    chk({31'h0, wdt_reset}, 32'h0);
    cpu_sleeping <= 1'b0;
    $display("test pause done");
    n = 0;
    @(posedge mclk);
    while (publish_pulse !== 1'b1 && n < 300) begin
      @(posedge mclk);
      n++;
    end
    chk({16'h0, publish_channel}, 32'h000000AB);
    chk({31'h0, wdt_reset}, 32'h0);
    @(posedge mclk);
    chk({31'h0, irq}, 32'h1);
    wait_reset_out(40);
    chk({31'h0, (n >= DIV) && (n <= 2 * DIV + 3)}, 32'h1);
    apb(1'b1, OFF_IRQ_CLR, 32'h1);
    repeat (2) @(posedge mclk);
    chk({31'h0, irq}, 32'h0);
    rdchk(OFF_IRQ_SET, 32'h0);
    rdchk(OFF_EVENT, 32'h1);
    apb(1'b1, OFF_EVENT, 32'h0);
    rdchk(OFF_EVENT, 32'h0);
    $display("test timeout with irq done");
    do_reset();
    chk({31'h0, wdt_reset}, 32'h0);
    n_pulse = 0;
    apb(1'b1, OFF_CRV, 32'h3);
    rdchk(OFF_CRV, 32'h3);
    cpu_sleeping <= 1'b1;
    apb(1'b1, OFF_START, 32'h1);
    wait_reset_out(60);
    chk({31'h0, (n >= 3 * DIV) && (n <= 5 * DIV + 4)}, 32'h1);
    chk(n_pulse, 0);
    $display("test short period done");
    final_report();
  end
endmodule
